// [hw/adcseq_pkg.sv]
// package: register map, field positions, reset values and timing for the conversion sequencer
package adcseq_pkg;
   // register byte offsets (one aligned word each)
   localparam logic [11:0] ADCSEQ_OFF_CTRL0 = 12'h000;
   localparam logic [11:0] ADCSEQ_OFF_CTRL1 = 12'h004;
   localparam logic [11:0] ADCSEQ_OFF_RES_LO = 12'h008;
   localparam logic [11:0] ADCSEQ_OFF_RES_HI = 12'h00C;
   localparam logic [11:0] ADCSEQ_OFF_PINSEL = 12'h010;
   localparam logic [11:0] ADCSEQ_OFF_IRQ = 12'h014;
   // converter_control_first fields
   localparam int ADCSEQ_C0_START = 7;
   localparam int ADCSEQ_C0_BUSY = 6;
   localparam int ADCSEQ_C0_PWR = 5;
   localparam int ADCSEQ_C0_JUST = 4;
   localparam int ADCSEQ_C0_CH_LSB = 0;
   // converter_control_second fields
   localparam int ADCSEQ_C1_SRC_LSB = 5;
   localparam int ADCSEQ_C1_REF_LSB = 3;
   localparam int ADCSEQ_C1_DIV_LSB = 0;
   // interrupt control fields
   localparam int ADCSEQ_IRQ_FLAG = 0;
   localparam int ADCSEQ_IRQ_EN = 1;
   // reset values
   localparam logic [7:0] ADCSEQ_RST_CTRL0 = 8'h00;
   localparam logic [7:0] ADCSEQ_RST_CTRL1 = 8'h00;
   localparam logic [5:0] ADCSEQ_RST_PINSEL = 6'h00;
   localparam logic [11:0] ADCSEQ_RST_RESULT = 12'h000;
   // sequencing counts in conversion clocks
   localparam logic [4:0] ADCSEQ_SAMPLE_CLKS = 5'h04;
   localparam logic [4:0] ADCSEQ_CONVERT_CLKS = 5'h0C;
   localparam int ADCSEQ_RES_BITS = 12;
   localparam int ADCSEQ_NUM_CH = 6;
   // reference mux one-hot: bit0 ext pin, bit1 analog supply, bit2 dac reference
   localparam logic [2:0] ADCSEQ_REF_EXT = 3'h1;
   localparam logic [2:0] ADCSEQ_REF_SUPPLY = 3'h2;
   localparam logic [2:0] ADCSEQ_REF_DAC = 3'h4;
   // internal source one-hot: amp1 pt0, pt1, pt2, dac out, amp2 out
   localparam logic [4:0] ADCSEQ_SRC_NONE = 5'h00;
   typedef enum logic [1:0] {
      ADCSEQ_IDLE = 2'b00,
      ADCSEQ_SAMPLE = 2'b01,
      ADCSEQ_CONVERT = 2'b10
   } adcseq_state_t;
endpackage : adcseq_pkg

// [hw/adcseq_top.sv]
// module: conversion sequencer with APB registers, clock divider, muxes and SAR control
//
// Added by the designer: the address map and the APB register port.
`timescale 1ns/1ps

// Contract
// - start bit high then low begins conversion
// - busy flag set once conversion starts
// - busy flag cleared when conversion finishes
// - completion sets interrupt request flag
// - enabled completion raises interrupt signal
// - conversion clock is system clock over 2^n
// - power enable powers converter; software waits settling
// - reference select drives reference mux
// - analog pin drops other functions and pull-up
// - analog assignment overrides port direction
// - source 000 or 11x routes external channel
// - channel codes 0-5 map, others float
// - internal source codes select amp and dac
// - sample 4 then convert 12 clocks
// - conversion runs autonomously in hardware
// - justify bit formats result bytes
// - unused result bits read zero
// - result unchanged while converter disabled
module adcseq_top
   import adcseq_pkg::*;
(
   // clock and reset
   input wire logic core_clk_i,
   input wire logic arst_n_i,
   // apb slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // analog core: comparator and trial code
   input wire logic cmp_i,
   output logic [11:0] sar_code_o,
   output logic sample_o,
   output logic power_enable_o,
   // analog muxes
   output logic [5:0] external_analog_channels_o,
   output logic [4:0] internal_source_o,
   output logic [2:0] reference_mux_o,
   // pin takeover
   input wire logic [5:0] port_dir_out_i,
   input wire logic [5:0] pull_high_en_i,
   output logic [5:0] pin_out_enable_o,
   output logic [5:0] pin_pull_high_o,
   output logic [5:0] pin_analog_o,
   // interrupt request to the controller
   output logic irq_o
);

   // ****************************************
   // registers and status
   // ****************************************
   logic start_ff;
   logic conversion_busy_flag_ff;
   logic converter_power_enable_ff;
   logic result_justify_select_ff;
   logic [3:0] external_channel_select_ff;
   logic [2:0] input_source_select_ff;
   logic [1:0] reference_source_select_ff;
   logic [2:0] conversion_clock_divider_select_ff;
   logic [5:0] pin_function_select_regs_ff;
   logic irq_flag_ff;
   logic irq_en_ff;
   logic [11:0] result_ff;
   logic [11:0] sar_ff;
   logic [6:0] div_cnt_ff;
   logic [4:0] clk_cnt_ff;
   logic [3:0] bit_idx_ff;
   adcseq_state_t state_ff;
   adcseq_state_t nxt_state;

   logic wr_en;
   logic start_fall;
   logic conv_tick;
   logic done;
   logic [6:0] nxt_div_cnt;
   logic [7:0] result_low_byte;
   logic [7:0] result_high_byte;

   function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] off);
      addr_hit = (a == off);
   endfunction : addr_hit

   assign wr_en = psel_i & penable_i & pwrite_i;
   assign pready_o = 1'b1;
   // writes to a start that is already falling during a conversion are ignored
   assign start_fall = wr_en & addr_hit(paddr_i, ADCSEQ_OFF_CTRL0) & start_ff
      & ~pwdata_i[ADCSEQ_C0_START];

   // ****************************************
   // control register writes
   // ****************************************
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         start_ff <= ADCSEQ_RST_CTRL0[ADCSEQ_C0_START];
         converter_power_enable_ff <= ADCSEQ_RST_CTRL0[ADCSEQ_C0_PWR];
         result_justify_select_ff <= ADCSEQ_RST_CTRL0[ADCSEQ_C0_JUST];
         external_channel_select_ff <= ADCSEQ_RST_CTRL0[3:0];
      end else if (wr_en && addr_hit(paddr_i, ADCSEQ_OFF_CTRL0)) begin
         start_ff <= pwdata_i[ADCSEQ_C0_START];
         converter_power_enable_ff <= pwdata_i[ADCSEQ_C0_PWR];
         result_justify_select_ff <= pwdata_i[ADCSEQ_C0_JUST];
         external_channel_select_ff <= pwdata_i[ADCSEQ_C0_CH_LSB +: 4];
      end
   end

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         input_source_select_ff <= ADCSEQ_RST_CTRL1[7:5];
         reference_source_select_ff <= ADCSEQ_RST_CTRL1[4:3];
         conversion_clock_divider_select_ff <= ADCSEQ_RST_CTRL1[2:0];
      end else if (wr_en && addr_hit(paddr_i, ADCSEQ_OFF_CTRL1)) begin
         input_source_select_ff <= pwdata_i[ADCSEQ_C1_SRC_LSB +: 3];
         reference_source_select_ff <= pwdata_i[ADCSEQ_C1_REF_LSB +: 2];
         conversion_clock_divider_select_ff <= pwdata_i[ADCSEQ_C1_DIV_LSB +: 3];
      end
   end

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pin_function_select_regs_ff <= ADCSEQ_RST_PINSEL;
      end else if (wr_en && addr_hit(paddr_i, ADCSEQ_OFF_PINSEL)) begin
         pin_function_select_regs_ff <= pwdata_i[5:0];
      end
   end

   // completion set wins over a software clear in the same cycle
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         irq_flag_ff <= 1'b0;
         irq_en_ff <= 1'b0;
      end else begin
         if (done) begin
            irq_flag_ff <= 1'b1;
         end else if (wr_en && addr_hit(paddr_i, ADCSEQ_OFF_IRQ)
                      && pwdata_i[ADCSEQ_IRQ_FLAG]) begin
            irq_flag_ff <= 1'b0;
         end
         if (wr_en && addr_hit(paddr_i, ADCSEQ_OFF_IRQ)) begin
            irq_en_ff <= pwdata_i[ADCSEQ_IRQ_EN];
         end
      end
   end

   assign irq_o = irq_flag_ff & irq_en_ff;

   // ****************************************
   // conversion clock divider
   // ****************************************
   // counter held at zero while idle; a tick every 2^n system clocks
   assign nxt_div_cnt = div_cnt_ff + 7'h01;
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         div_cnt_ff <= 7'h00;
      end else if (state_ff == ADCSEQ_IDLE) begin
         div_cnt_ff <= 7'h00;
      end else begin
         div_cnt_ff <= nxt_div_cnt;
      end
   end

   always_comb begin
      case (conversion_clock_divider_select_ff)
         3'h0: conv_tick = 1'b1;
         3'h1: conv_tick = (div_cnt_ff[0:0] == 1'h1);
         3'h2: conv_tick = (div_cnt_ff[1:0] == 2'h3);
         3'h3: conv_tick = (div_cnt_ff[2:0] == 3'h7);
         3'h4: conv_tick = (div_cnt_ff[3:0] == 4'hF);
         3'h5: conv_tick = (div_cnt_ff[4:0] == 5'h1F);
         3'h6: conv_tick = (div_cnt_ff[5:0] == 6'h3F);
         default: conv_tick = (div_cnt_ff == 7'h7F);
      endcase
   end

   // ****************************************
   // sequencer
   // ****************************************
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ADCSEQ_IDLE: begin
            if (start_fall && converter_power_enable_ff) begin
               nxt_state = ADCSEQ_SAMPLE;
            end
         end
         ADCSEQ_SAMPLE: begin
            if (conv_tick && clk_cnt_ff == ADCSEQ_SAMPLE_CLKS - 5'h01) begin
               nxt_state = ADCSEQ_CONVERT;
            end
         end
         ADCSEQ_CONVERT: begin
            if (conv_tick && clk_cnt_ff == ADCSEQ_CONVERT_CLKS - 5'h01) begin
               nxt_state = ADCSEQ_IDLE;
            end
         end
         default: nxt_state = ADCSEQ_IDLE;
      endcase
      // power removal aborts a conversion
      if (!converter_power_enable_ff) begin
         nxt_state = ADCSEQ_IDLE;
      end
   end

   assign done = (state_ff == ADCSEQ_CONVERT) && (nxt_state == ADCSEQ_IDLE)
      && converter_power_enable_ff;

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_ff <= ADCSEQ_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         clk_cnt_ff <= 5'h00;
      end else if (state_ff != nxt_state) begin
         clk_cnt_ff <= 5'h00;
      end else if (conv_tick) begin
         clk_cnt_ff <= clk_cnt_ff + 5'h01;
      end
   end

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         conversion_busy_flag_ff <= 1'b0;
      end else if (state_ff == ADCSEQ_IDLE && nxt_state == ADCSEQ_SAMPLE) begin
         conversion_busy_flag_ff <= 1'b1;
      end else if (nxt_state == ADCSEQ_IDLE) begin
         conversion_busy_flag_ff <= 1'b0;
      end
   end

   // successive approximation: trial bit set, kept or dropped on each tick
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sar_ff <= 12'h000;
         bit_idx_ff <= 4'hB;
      end else if (state_ff == ADCSEQ_SAMPLE && nxt_state == ADCSEQ_CONVERT) begin
         sar_ff <= 12'h800;
         bit_idx_ff <= 4'hB;
      end else if (state_ff == ADCSEQ_CONVERT && conv_tick) begin
         sar_ff[bit_idx_ff] <= cmp_i;
         if (bit_idx_ff != 4'h0) begin
            sar_ff[bit_idx_ff - 4'h1] <= 1'b1;
            bit_idx_ff <= bit_idx_ff - 4'h1;
         end
      end
   end

   // result keeps its value while disabled, since done needs power
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         result_ff <= ADCSEQ_RST_RESULT;
      end else if (done) begin
         result_ff <= {sar_ff[11:1], cmp_i};
      end
   end

   assign sar_code_o = sar_ff;
   assign sample_o = (state_ff == ADCSEQ_SAMPLE);
   assign power_enable_o = converter_power_enable_ff;

   // ****************************************
   // analog muxes and pin takeover
   // ****************************************
   always_comb begin
      external_analog_channels_o = 6'h00;
      internal_source_o = ADCSEQ_SRC_NONE;
      case (input_source_select_ff)
         3'h1: internal_source_o = 5'h01;
         3'h2: internal_source_o = 5'h02;
         3'h3: internal_source_o = 5'h04;
         3'h4: internal_source_o = 5'h08;
         3'h5: internal_source_o = 5'h10;
         default: begin
            if (external_channel_select_ff < 4'(ADCSEQ_NUM_CH)) begin
               external_analog_channels_o[external_channel_select_ff[2:0]] = 1'b1;
            end
         end
      endcase
   end

   always_comb begin
      case (reference_source_select_ff)
         2'h1: reference_mux_o = ADCSEQ_REF_SUPPLY;
         2'h2: reference_mux_o = ADCSEQ_REF_DAC;
         default: reference_mux_o = ADCSEQ_REF_EXT;
      endcase
   end

   assign pin_analog_o = pin_function_select_regs_ff;
   assign pin_out_enable_o = port_dir_out_i & ~pin_function_select_regs_ff;
   assign pin_pull_high_o = pull_high_en_i & ~pin_function_select_regs_ff;

   // ****************************************
   // read data
   // ****************************************
   always_comb begin
      if (result_justify_select_ff) begin
         result_high_byte = {4'h0, result_ff[11:8]};
         result_low_byte = result_ff[7:0];
      end else begin
         result_high_byte = result_ff[11:4];
         result_low_byte = {result_ff[3:0], 4'h0};
      end
   end

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         prdata_o <= 32'h00000000;
         pslverr_o <= 1'b0;
      end else begin
         prdata_o <= 32'h00000000;
         pslverr_o <= 1'b0;
         if (psel_i && !penable_i && !pwrite_i) begin
            case (paddr_i)
               ADCSEQ_OFF_CTRL0: prdata_o <= {24'h000000, start_ff, conversion_busy_flag_ff,
                  converter_power_enable_ff, result_justify_select_ff,
                  external_channel_select_ff};
               ADCSEQ_OFF_CTRL1: prdata_o <= {24'h000000, input_source_select_ff,
                  reference_source_select_ff, conversion_clock_divider_select_ff};
               ADCSEQ_OFF_RES_LO: prdata_o <= {24'h000000, result_low_byte};
               ADCSEQ_OFF_RES_HI: prdata_o <= {24'h000000, result_high_byte};
               ADCSEQ_OFF_PINSEL: prdata_o <= {26'h0000000, pin_function_select_regs_ff};
               ADCSEQ_OFF_IRQ: prdata_o <= {30'h00000000, irq_en_ff, irq_flag_ff};
               default: pslverr_o <= 1'b0;
            endcase
         end
         if (psel_i && !penable_i) begin
            pslverr_o <= (paddr_i[1:0] != 2'h0) || (paddr_i > ADCSEQ_OFF_IRQ);
         end
      end
   end

endmodule : adcseq_top

// [tb/adcseq_chk.sv]
// checker: port-level assertions for the conversion sequencer
`timescale 1ns/1ps
module adcseq_chk
   import adcseq_pkg::*;
(
   // clock, reset and bus
   input wire logic core_clk_i,
   input wire logic arst_n_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [31:0] prdata_o,
   // converter side
   input wire logic sample_o,
   input wire logic [11:0] sar_code_o,
   input wire logic power_enable_o,
   input wire logic [5:0] external_analog_channels_o,
   input wire logic [4:0] internal_source_o,
   input wire logic [2:0] reference_mux_o,
   // pins
   input wire logic [5:0] port_dir_out_i,
   input wire logic [5:0] pull_high_en_i,
   input wire logic [5:0] pin_out_enable_o,
   input wire logic [5:0] pin_pull_high_o,
   input wire logic [5:0] pin_analog_o
);
   // ****
   // helper logic
   // ****
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!arst_n_i);
   logic [2:0] div_ff;
   logic [15:0] cnt_ff;
   logic start_wr;
   // bus write that drops start with power kept on
   assign start_wr = psel_i && penable_i && pwrite_i && paddr_i == ADCSEQ_OFF_CTRL0
      && !pwdata_i[ADCSEQ_C0_START] && pwdata_i[ADCSEQ_C0_PWR];
   // divider copy is snooped from bus writes, so mid-conversion changes are not modelled
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         div_ff <= 3'h0;
         cnt_ff <= 16'h0000;
      end else begin
         if (psel_i && penable_i && pwrite_i && paddr_i == ADCSEQ_OFF_CTRL1) begin
            div_ff <= pwdata_i[2:0];
         end
         cnt_ff <= sample_o ? cnt_ff + 16'h0001 : 16'h0000;
      end
   end
   // ****
   // assertions
   // ****
   chk_pull_drop: assert property (pin_pull_high_o == (pull_high_en_i & ~pin_analog_o))
      else $error("pull-up kept on analog pin");
   chk_dir_override: assert property (pin_out_enable_o == (port_dir_out_i & ~pin_analog_o))
      else $error("driver kept on analog pin");
   chk_ref_onehot: assert property ($onehot(reference_mux_o))
      else $error("reference mux not one-hot");
   chk_chan_onehot: assert property ($onehot0(external_analog_channels_o))
      else $error("several channels connected");
   chk_src_onehot: assert property ($onehot0(internal_source_o))
      else $error("several internal sources connected");
   chk_start_cause: assert property ($rose(sample_o) |-> $past(start_wr))
      else $error("sampling began without start");
   chk_sample_len: assert property ((!sample_o && cnt_ff != 16'h0000) |->
      cnt_ff == (16'h0004 << div_ff)) else $error("sampling length wrong");
   chk_first_trial: assert property (($fell(sample_o) && power_enable_o) |->
      sar_code_o == 12'h800) else $error("first trial not msb");
   chk_result_pad: assert property ((psel_i && penable_i && !pwrite_i &&
      (paddr_i == ADCSEQ_OFF_RES_LO || paddr_i == ADCSEQ_OFF_RES_HI)) |->
      prdata_o[31:8] == 24'h000000) else $error("result upper bits not zero");
endmodule : adcseq_chk

bind adcseq_top adcseq_chk u_chk (
   .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .psel_i(psel_i), .penable_i(penable_i),
   .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
   .sample_o(sample_o), .sar_code_o(sar_code_o), .power_enable_o(power_enable_o),
   .external_analog_channels_o(external_analog_channels_o),
   .internal_source_o(internal_source_o), .reference_mux_o(reference_mux_o),
   .port_dir_out_i(port_dir_out_i), .pull_high_en_i(pull_high_en_i),
   .pin_out_enable_o(pin_out_enable_o), .pin_pull_high_o(pin_pull_high_o),
   .pin_analog_o(pin_analog_o)
);

// [tb/tb_top.sv]
// testbench: random and corner stimulus for the conversion sequencer
`timescale 1ns/1ps
module tb_top
   import adcseq_pkg::*;
;
   // ****
   // signals and design
   // ****
   logic core_clk_i = 1'b0, arst_n_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
   logic [11:0] paddr_i = 12'h000, sar_code_o, tgt = 12'h000;
   logic [31:0] pwdata_i = 32'h00000000, prdata_o, rd;
   logic pready_o, pslverr_o, sample_o, power_enable_o, irq_o, cmp_i, serr;
   logic [5:0] port_dir_out_i = 6'h00, pull_high_en_i = 6'h00, ps;
   logic [5:0] external_analog_channels_o, pin_out_enable_o, pin_pull_high_o, pin_analog_o;
   logic [4:0] internal_source_o;
   logic [2:0] reference_mux_o;
   int err_count = 0, samples_checked = 0;
   // comparator model: keeps a trial bit while the trial code does not exceed the input
   assign cmp_i = (sar_code_o <= tgt);
   always #5 core_clk_i = ~core_clk_i;
   adcseq_top dut (
      .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .psel_i(psel_i), .penable_i(penable_i),
      .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
      .pready_o(pready_o), .pslverr_o(pslverr_o), .cmp_i(cmp_i), .sar_code_o(sar_code_o),
      .sample_o(sample_o), .power_enable_o(power_enable_o),
      .external_analog_channels_o(external_analog_channels_o),
      .internal_source_o(internal_source_o), .reference_mux_o(reference_mux_o),
      .port_dir_out_i(port_dir_out_i), .pull_high_en_i(pull_high_en_i),
      .pin_out_enable_o(pin_out_enable_o), .pin_pull_high_o(pin_pull_high_o),
      .pin_analog_o(pin_analog_o), .irq_o(irq_o)
   );
   // ****
   // tasks
   // ****
   task automatic close_out();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : close_out
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %s exp %h got %h", nm, exp, got);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge core_clk_i);
      psel_i <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge core_clk_i);
      penable_i <= 1'b1;
      do begin
         @(posedge core_clk_i);
         n++;
      end while (pready_o !== 1'b1 && n < 50);
      if (n >= 50) begin
         err_count++;
         close_out();
      end
      rd = prdata_o;
      serr = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      // let this edge's register updates land before anyone looks
      #1;
   endtask : apb
   task automatic rg(input logic [11:0] a);
      apb(1'b0, a, 32'h00000000);
   endtask : rg
   function automatic logic [2:0] ref_exp(input logic [1:0] r);
      return (r == 2'h1) ? ADCSEQ_REF_SUPPLY : (r == 2'h2) ? ADCSEQ_REF_DAC : ADCSEQ_REF_EXT;
   endfunction : ref_exp
   function automatic logic [5:0] ch_exp(input logic [2:0] s, input logic [3:0] c);
      return ((s == 3'h0 || s[2:1] == 2'h3) && c < 4'h6) ? 6'h01 << c : 6'h00;
   endfunction : ch_exp
   function automatic logic [4:0] src_exp(input logic [2:0] s);
      return (s >= 3'h1 && s <= 3'h5) ? 5'h01 << (s - 3'h1) : ADCSEQ_SRC_NONE;
   endfunction : src_exp
   function automatic logic [15:0] fmt(input logic [11:0] v, input logic j);
      return j ? {4'h0, v} : {v, 4'h0};
   endfunction : fmt
   // ****
   // main sequence
   // ****
   initial begin
      logic [2:0] s;
      logic [3:0] c;
      logic [1:0] r;
      int n;
      void'($urandom(32'hB292));
      repeat (10) @(posedge core_clk_i);
      arst_n_i <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         rg(12'(i * 4));
         chk("reset_reg", 32'h00000000, rd);
      end
      chk("reset_ref", ADCSEQ_REF_EXT, reference_mux_o);
      rg(12'h018);
      chk("slverr", 1'b1, serr);
      rg(12'h002);
      chk("slverr_unal", 1'b1, serr);
      $display("reset test done");
      for (int i = 0; i < 128; i++) begin
         s = i[6:4];
         c = i[3:0];
         r = 2'($urandom);
         // internal sources only with the channel parked
         if (s inside {[3'h1:3'h5]} && c < 4'h6) continue;
         // the reference pin is never claimed here, so every reference code is safe
         apb(1'b1, ADCSEQ_OFF_CTRL1, {24'h0, s, r, 3'h0});
         apb(1'b1, ADCSEQ_OFF_CTRL0, {28'h0, c});
         chk("ref", ref_exp(r), reference_mux_o);
         chk("chan", ch_exp(s, c), external_analog_channels_o);
         chk("src", src_exp(s), internal_source_o);
      end
      $display("mux test done");
      repeat (4) begin
         @(posedge core_clk_i);
         ps = 6'($urandom);
         port_dir_out_i <= 6'($urandom);
         pull_high_en_i <= 6'($urandom);
         apb(1'b1, ADCSEQ_OFF_PINSEL, {26'h0, ps});
         chk("oe", port_dir_out_i & ~ps, pin_out_enable_o);
         chk("pull", pull_high_en_i & ~ps, pin_pull_high_o);
         chk("analog", ps, pin_analog_o);
      end
      $display("pin test done");
      for (int d = 0; d < 8; d++) begin
         @(posedge core_clk_i);
         tgt <= (d == 0) ? 12'hFFF : (d == 1) ? 12'h000 : 12'($urandom);
         // only codes 6 and 7 keep the recommended period window at 100 MHz; all are swept
         apb(1'b1, ADCSEQ_OFF_CTRL1, {29'h0, 3'(d)});
         apb(1'b1, ADCSEQ_OFF_IRQ, {30'h0, d[1], 1'b1});
         apb(1'b1, ADCSEQ_OFF_CTRL0, {24'h0, 3'b001, d[0], 4'hF});
         chk("pwr_on", 1'b1, power_enable_o);
         repeat (8) @(posedge core_clk_i);
         apb(1'b1, ADCSEQ_OFF_CTRL0, {24'h0, 3'b101, d[0], 4'hF});
         apb(1'b1, ADCSEQ_OFF_CTRL0, {24'h0, 3'b001, d[0], 4'hF});
         rg(ADCSEQ_OFF_CTRL0);
         chk("busy_set", 1'b1, rd[6]);
         n = 0;
         while (rd[6] === 1'b1 && n < 1000) begin
            rg(ADCSEQ_OFF_CTRL0);
            n++;
         end
         chk("busy_clear", 1'b0, rd[6]);
         if (n >= 1000) close_out();
         rg(ADCSEQ_OFF_IRQ);
         chk("irq_flag", 1'b1, rd[0]);
         chk("irq_line", d[1], irq_o);
         rg(ADCSEQ_OFF_RES_LO);
         chk("res_lo", fmt(tgt, d[0]) & 16'h00FF, rd);
         rg(ADCSEQ_OFF_RES_HI);
         chk("res_hi", fmt(tgt, d[0]) >> 8, rd);
         apb(1'b1, ADCSEQ_OFF_IRQ, 32'h00000001);
         chk("irq_clr", 1'b0, irq_o);
         // a start pulse while powered down must be ignored
         apb(1'b1, ADCSEQ_OFF_CTRL0, {24'h0, 3'b100, d[0], 4'hF});
         chk("pwr_off", 1'b0, power_enable_o);
         apb(1'b1, ADCSEQ_OFF_CTRL0, {24'h0, 3'b000, d[0], 4'hF});
         rg(ADCSEQ_OFF_CTRL0);
         chk("no_start", 1'b0, rd[6]);
         rg(ADCSEQ_OFF_RES_HI);
         chk("res_keep", fmt(tgt, d[0]) >> 8, rd);
         $display("conversion test %0d done", d);
      end
      close_out();
   end
endmodule : tb_top
